// file: core/instruction_cycle_timing_defines.svh
// timing constants and table entries for the instruction cycle model
// Function
// [RULE_01] each total already holds its read, prefetch and write clocks
// [RULE_02] figures assume two-clock bus cycles; wait states lengthen totals
// [RULE_03] register to space or cache control: 12 clocks, head 4, no data
// [RULE_04] register to stack, vector or cache address: 6 clocks, head 6
// [RULE_05] register list load: 8+4n, plus (w-2)n above two waits, tail 0
// [RULE_06] register list store: 4+2n+(n-1)w, waits above two add more
// [RULE_07] status load: 8 clocks cached, 10 with two prefetches, plus EA
// [RULE_08] alternate space load: 7 clocks, one read, plus address time
// [RULE_09] register ALU 2 clocks; memory ALU 3 cached, 4 uncached
// [RULE_10] double indirect move destination: 20 cached, 23 uncached
// [RULE_11] special alternate_space_move count the whole operation; flagged EA time added
// [RULE_12] multiply and divide report maximum time, flagged as such
// [RULE_13] head, tail and total exposed per executed instruction
`ifndef INSTRUCTION_CYCLE_TIMING_DEFINES_SVH
`define INSTRUCTION_CYCLE_TIMING_DEFINES_SVH

`define TIME_W      10
`define CNT_W       5
`define WAIT_W      4
`define LIST_W      5
`define EA_W        8
`define WAIT_FREE   2
`define LOAD_BASE   8
`define LOAD_STEP   4
`define STORE_BASE  4
`define STORE_STEP  2

// head, tail, total cached, total uncached, reads,
// prefetch cached, prefetch uncached, writes, ea added, maximum
`define ENT(h,t,c,u,r,pc,pu,w,e,m) {8'(h), 8'(t), 8'(c), 8'(u), \
  4'(r), 4'(pc), 4'(pu), 4'(w), 1'(e), 1'(m)}

`define E_EXCHANGE  `ENT(4,0,4,4,0,0,1,0,0,0)
`define E_CTL_REG   `ENT(6,0,6,6,0,0,1,0,0,0)
`define E_CTL_A     `ENT(6,0,6,6,0,0,1,0,0,0)
`define E_CTL_B     `ENT(4,0,12,12,0,0,1,0,0,0)
`define E_COND_REG  `ENT(2,0,4,4,0,0,1,0,0,0)
`define E_COND_MEM  `ENT(2,0,4,5,0,0,1,1,0,0)
`define E_REG_COND  `ENT(4,0,4,4,0,0,1,0,0,0)
`define E_EA_COND   `ENT(0,0,4,4,0,0,1,0,0,0)
`define E_STAT_REG  `ENT(2,0,4,4,0,0,1,0,0,0)
`define E_STAT_MEM  `ENT(2,0,4,5,0,0,1,1,0,0)
`define E_EA_STAT   `ENT(0,0,8,10,0,0,2,0,1,0)
`define E_LIST_LD   `ENT(2,0,8,8,0,0,1,0,1,0)
`define E_LIST_ST   `ENT(2,0,4,4,0,0,1,0,1,0)
`define E_PER_W_OUT `ENT(4,0,10,10,0,0,1,2,0,0)
`define E_PER_W_IN  `ENT(2,0,10,10,2,0,1,0,0,0)
`define E_PER_L_OUT `ENT(4,0,14,14,0,0,1,4,0,0)
`define E_PER_L_IN  `ENT(2,0,14,14,4,0,1,0,0,0)
`define E_ALT_LD    `ENT(3,0,7,7,1,0,1,0,1,0)
`define E_ALT_ST    `ENT(2,1,5,6,0,0,1,1,1,0)
`define E_USER_SP   `ENT(4,0,4,4,0,0,1,0,0,0)
`define E_SWAP      `ENT(4,0,4,4,0,0,1,0,0,0)
`define E_ALU_REG   `ENT(2,0,2,2,0,0,1,0,0,0)
`define E_ALU_EA    `ENT(0,0,2,2,0,0,1,0,1,0)
`define E_ALU_MEM   `ENT(0,1,3,4,0,0,1,1,1,0)
`define E_MOVE_D16  `ENT(2,0,8,9,0,0,2,1,1,0)
`define E_MOVE_DBL  `ENT(4,0,20,23,1,0,3,1,1,0)
`define E_MUL_W     `ENT(2,0,28,28,0,0,1,0,1,1)
`define E_MUL_L     `ENT(2,0,44,44,0,0,1,0,1,1)
`define E_DIVS_W    `ENT(2,0,56,56,0,0,1,0,1,1)
`define E_DIVS_L    `ENT(2,0,90,90,0,0,1,0,1,1)
`define E_DIVU_W    `ENT(2,0,44,44,0,0,1,0,1,1)
`define E_DIVU_L    `ENT(2,0,78,78,0,0,1,0,1,1)

`endif

// file: core/cycle_timing_pkg.sv
// types shared by the instruction cycle model
package cycle_timing_pkg;

  typedef enum logic [4:0] {
    OP_EXCHANGE, OP_CTL_TO_REG, OP_REG_TO_CTL_A, OP_REG_TO_CTL_B,
    OP_COND_TO_REG, OP_COND_TO_MEM, OP_REG_TO_COND, OP_EA_TO_COND,
    OP_STAT_TO_REG, OP_STAT_TO_MEM, OP_EA_TO_STAT, OP_LIST_LOAD,
    OP_LIST_STORE, OP_PER_W_OUT, OP_PER_W_IN, OP_PER_L_OUT,
    OP_PER_L_IN, OP_ALT_LOAD, OP_ALT_STORE, OP_USER_STACK_MOVE,
    OP_SWAP, OP_ALU_REG, OP_ALU_EA_REG, OP_ALU_MEM,
    OP_MOVE_D16, OP_MOVE_DBL_IND, OP_MUL_W, OP_MUL_L,
    OP_DIVS_W, OP_DIVS_L, OP_DIVU_W, OP_DIVU_L
  } op_t;

  typedef struct packed {
    logic [7:0] head;
    logic [7:0] tail;
    logic [7:0] tot_c;
    logic [7:0] tot_u;
    logic [3:0] rd;
    logic [3:0] pf_c;
    logic [3:0] pf_u;
    logic [3:0] wr;
    logic       ea_add;
    logic       max_time;
  } entry_t;

  typedef enum logic [1:0] {
    PH_IDLE, PH_HEAD, PH_BODY, PH_TAIL
  } phase_t;

endpackage

// file: core/execution_counter.sv
// clock counter that spans one instruction's execution
`timescale 1ns/100ps
`include "instruction_cycle_timing_defines.svh"
module execution_counter #(
  parameter int W = `TIME_W
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         load,
  input  wire logic [W-1:0] length,
  output logic              busy,
  output logic              last,
  output logic [W-1:0]      elapsed
);

  logic [W-1:0] remaining;
  logic [W-1:0] next_remaining;
  logic [W-1:0] next_elapsed;

  always_comb begin
    next_remaining = remaining;
    next_elapsed   = elapsed;
    if (load) begin
      next_remaining = length;
      next_elapsed   = '0;
    end else if (remaining != '0) begin
      next_remaining = remaining - W'(1);
      next_elapsed   = elapsed + W'(1);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      remaining <= '0;
      elapsed   <= '0;
    end else begin
      remaining <= next_remaining;
      elapsed   <= next_elapsed;
    end
  end

  assign busy = (remaining != '0);
  assign last = (remaining == W'(1));

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  run_start_a: assert property (load && length != '0 |=>
    busy && elapsed == '0) // see [RULE_13]
    else $error("counter did not start");
  run_end_a: assert property (last && !load |=> !busy) // see [RULE_13]
    else $error("counter ran past its length");

endmodule

// file: core/reg_list_timing.sv
// clock formulas for the register list move with wait states
`timescale 1ns/100ps
`include "instruction_cycle_timing_defines.svh"
module reg_list_timing #(
  parameter int W = `TIME_W
) (
  input  wire logic [`LIST_W-1:0] count,
  input  wire logic [`WAIT_W-1:0] waits,
  input  wire logic               store,
  output logic [W-1:0]            total,
  output logic [W-1:0]            tail
);

  logic [W-1:0] n;
  logic [W-1:0] w;
  logic [W-1:0] over;

  // zero registers is not a legal list; treated as one
  assign n = (count == '0) ? W'(1) : W'(count);
  assign w = W'(waits);
  assign over = (w > W'(`WAIT_FREE)) ? w - W'(`WAIT_FREE) : '0;

  always_comb begin
    total = '0;
    tail  = '0;
    if (!store) begin
      total = W'(`LOAD_BASE) + W'(`LOAD_STEP) * n + over * n; // see [RULE_05]
      tail  = '0; // see [RULE_05]
    end else begin
      total = W'(`STORE_BASE) + W'(`STORE_STEP) * n
            + (n - W'(1)) * w + over; // see [RULE_06]
      if (w > W'(`WAIT_FREE))
        tail = n * w + n * over; // see [RULE_06]
      else
        tail = (n - W'(1)) * w; // see [RULE_06]
    end
  end

endmodule

// file: core/instruction_cycle_timing.sv
// execution stage cycle count model with head and tail phases
`timescale 1ns/100ps
`include "instruction_cycle_timing_defines.svh"
module instruction_cycle_timing
  import cycle_timing_pkg::*;
#(
  parameter int TW = `TIME_W,
  parameter int CW = `CNT_W
) (
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire logic               start,
  input  wire op_t                op,
  input  wire logic               cache_hit,
  input  wire logic [`WAIT_W-1:0] wait_states,
  input  wire logic [`LIST_W-1:0] list_count,
  input  wire logic [`EA_W-1:0]   ea_clocks,
  output logic                    ready,
  output logic                    busy,
  output logic                    done,
  output phase_t                  phase,
  output logic [TW-1:0]           elapsed,
  output logic [TW-1:0]           head_clocks,
  output logic [TW-1:0]           tail_clocks,
  output logic [TW-1:0]           total_clocks,
  output logic [CW-1:0]           read_cycles,
  output logic [CW-1:0]           prefetch_cycles,
  output logic [CW-1:0]           write_cycles,
  output logic                    max_time
);

  function automatic entry_t table_of(input op_t code);
    entry_t e;
    e = '0;
    unique case (code)
      OP_EXCHANGE:        e = `E_EXCHANGE;
      OP_CTL_TO_REG:      e = `E_CTL_REG;
      OP_REG_TO_CTL_A:    e = `E_CTL_A; // see [RULE_04]
      OP_REG_TO_CTL_B:    e = `E_CTL_B; // see [RULE_03]
      OP_COND_TO_REG:     e = `E_COND_REG;
      OP_COND_TO_MEM:     e = `E_COND_MEM;
      OP_REG_TO_COND:     e = `E_REG_COND;
      OP_EA_TO_COND:      e = `E_EA_COND;
      OP_STAT_TO_REG:     e = `E_STAT_REG;
      OP_STAT_TO_MEM:     e = `E_STAT_MEM;
      OP_EA_TO_STAT:      e = `E_EA_STAT; // see [RULE_07]
      OP_LIST_LOAD:       e = `E_LIST_LD;
      OP_LIST_STORE:      e = `E_LIST_ST;
      OP_PER_W_OUT:       e = `E_PER_W_OUT;
      OP_PER_W_IN:        e = `E_PER_W_IN;
      OP_PER_L_OUT:       e = `E_PER_L_OUT;
      OP_PER_L_IN:        e = `E_PER_L_IN;
      OP_ALT_LOAD:        e = `E_ALT_LD; // see [RULE_08]
      OP_ALT_STORE:       e = `E_ALT_ST;
      OP_USER_STACK_MOVE: e = `E_USER_SP;
      OP_SWAP:            e = `E_SWAP;
      OP_ALU_REG:         e = `E_ALU_REG; // see [RULE_09]
      OP_ALU_EA_REG:      e = `E_ALU_EA;
      OP_ALU_MEM:         e = `E_ALU_MEM; // see [RULE_09]
      OP_MOVE_D16:        e = `E_MOVE_D16;
      OP_MOVE_DBL_IND:    e = `E_MOVE_DBL; // see [RULE_10]
      OP_MUL_W:           e = `E_MUL_W; // see [RULE_12]
      OP_MUL_L:           e = `E_MUL_L;
      OP_DIVS_W:          e = `E_DIVS_W;
      OP_DIVS_L:          e = `E_DIVS_L;
      OP_DIVU_W:          e = `E_DIVU_W;
      OP_DIVU_L:          e = `E_DIVU_L;
    endcase
    return e;
  endfunction

  entry_t       ent;
  logic         accept;
  logic         is_list;
  logic         last;
  logic [CW-1:0] pf;
  logic [CW-1:0] bus_cycles;
  logic [TW-1:0] base;
  logic [TW-1:0] stretch;
  logic [TW-1:0] ea_extra;
  logic [TW-1:0] list_total;
  logic [TW-1:0] list_tail;
  logic [TW-1:0] new_total;
  logic [TW-1:0] new_tail;
  logic [CW-1:0] new_reads;
  logic [CW-1:0] new_writes;
  logic [CW-1:0] list_n;

  assign list_n = (list_count == '0) ? CW'(1) : CW'(list_count);

  logic [TW-1:0] next_head;
  logic [TW-1:0] next_tail;
  logic [TW-1:0] next_total;
  logic [CW-1:0] next_reads;
  logic [CW-1:0] next_prefetch;
  logic [CW-1:0] next_writes;
  logic          next_max;

  reg_list_timing #(
    .W (TW)
  ) list_formula (
    .count (list_count),
    .waits (wait_states),
    .store (op == OP_LIST_STORE),
    .total (list_total),
    .tail  (list_tail)
  );

  execution_counter #(
    .W (TW)
  ) run_counter (
    .clock   (clock),
    .rstn    (rstn),
    .load    (accept),
    .length  (new_total),
    .busy    (busy),
    .last    (last),
    .elapsed (elapsed)
  );

  // a request while busy is dropped, so the source must watch ready
  assign ready  = !busy;
  assign accept = start && !busy;
  assign done   = last;
  assign is_list = (op == OP_LIST_LOAD) || (op == OP_LIST_STORE);

  always_comb begin
    ent = table_of(op);
    pf  = cache_hit ? CW'(ent.pf_c) : CW'(ent.pf_u);
    base = cache_hit ? TW'(ent.tot_c) : TW'(ent.tot_u);
    // bus clocks are inside the total already
    bus_cycles = CW'(ent.rd) + pf + CW'(ent.wr); // see [RULE_01]
    // every bus cycle beyond two clocks lengthens the run
    stretch = TW'(bus_cycles) * TW'(wait_states); // see [RULE_02]
    // flagged address times stack on the table figure
    ea_extra = ent.ea_add ? TW'(ea_clocks) : '0; // see [RULE_11]
    if (is_list) begin
      // the formula already folds in the list's waits
      new_total  = list_total + ea_extra; // see [RULE_05] [RULE_06]
      new_tail   = list_tail;
      // an empty list counts as one register, as in the formula
      new_reads  = (op == OP_LIST_LOAD) ? list_n : '0;
      new_writes = (op == OP_LIST_STORE) ? list_n : '0;
    end else begin
      new_total  = base + stretch + ea_extra;
      new_tail   = TW'(ent.tail);
      new_reads  = CW'(ent.rd);
      new_writes = CW'(ent.wr);
    end
  end

  always_comb begin
    next_head     = head_clocks;
    next_tail     = tail_clocks;
    next_total    = total_clocks;
    next_reads    = read_cycles;
    next_prefetch = prefetch_cycles;
    next_writes   = write_cycles;
    next_max      = max_time;
    if (accept) begin
      next_head     = TW'(ent.head); // see [RULE_13]
      next_tail     = new_tail; // see [RULE_13]
      next_total    = new_total; // see [RULE_13]
      next_reads    = new_reads; // see [RULE_01]
      next_prefetch = pf; // see [RULE_01]
      next_writes   = new_writes; // see [RULE_01]
      // data dependent ops may finish early; the figure is an upper bound
      next_max      = ent.max_time; // see [RULE_12]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      head_clocks     <= '0;
      tail_clocks     <= '0;
      total_clocks    <= '0;
      read_cycles     <= '0;
      prefetch_cycles <= '0;
      write_cycles    <= '0;
      max_time        <= 1'b0;
    end else begin
      head_clocks     <= next_head;
      tail_clocks     <= next_tail;
      total_clocks    <= next_total;
      read_cycles     <= next_reads;
      prefetch_cycles <= next_prefetch;
      write_cycles    <= next_writes;
      max_time        <= next_max;
    end
  end

  // head and tail may overlap the neighbours; head wins if they collide
  always_comb begin
    if (!busy)
      phase = PH_IDLE;
    else if (elapsed < head_clocks)
      phase = PH_HEAD; // see [RULE_13]
    else if (elapsed >= total_clocks - tail_clocks)
      phase = PH_TAIL; // see [RULE_13]
    else
      phase = PH_BODY;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  bus_included_a: assert property (accept && wait_states == '0 |=>
    total_clocks >= 2 * (read_cycles + prefetch_cycles
    + write_cycles)) // see [RULE_01]
    else $error("total misses its bus clocks");

  wait_stretch_a: assert property (accept && op == OP_ALU_MEM &&
    cache_hit |=> total_clocks == 10'h003 + $past(wait_states)
    + $past(ea_clocks)) // see [RULE_02]
    else $error("wait states not added");

  space_ctl_a: assert property (accept && op == OP_REG_TO_CTL_B &&
    cache_hit && wait_states == '0 |=>
    total_clocks == 10'h00C && head_clocks == 10'h004
    && read_cycles == '0 && write_cycles == '0) // see [RULE_03]
    else $error("space control move timing wrong");

  stack_ctl_a: assert property (accept && op == OP_REG_TO_CTL_A &&
    cache_hit && wait_states == '0 |=>
    total_clocks == 10'h006 && head_clocks == 10'h006
    && read_cycles == '0 && write_cycles == '0) // see [RULE_04]
    else $error("stack control move timing wrong");

  list_load_a: assert property (accept && op == OP_LIST_LOAD &&
    wait_states < 2 && list_count != '0 && ea_clocks == '0 |=>
    total_clocks == 10'h008 + 4 * $past(list_count)
    && tail_clocks == '0) // see [RULE_05]
    else $error("list load timing wrong");

  list_store_a: assert property (accept && op == OP_LIST_STORE &&
    wait_states <= 2 && list_count != '0 |=>
    tail_clocks == ($past(list_count) - 1) * $past(wait_states))
    // see [RULE_06]
    else $error("list store tail wrong");

  status_load_a: assert property (accept && op == OP_EA_TO_STAT &&
    !cache_hit && wait_states == '0 && ea_clocks == '0 |=>
    total_clocks == 10'h00A && prefetch_cycles == 5'h02)
    // see [RULE_07]
    else $error("status load timing wrong");

  alt_load_a: assert property (accept && op == OP_ALT_LOAD &&
    wait_states == '0 |=> total_clocks == 10'h007
    + $past(ea_clocks) && read_cycles == 5'h01) // see [RULE_08]
    else $error("alternate load timing wrong");

  alu_reg_a: assert property (accept && op == OP_ALU_REG &&
    !cache_hit && wait_states == '0 |=> total_clocks == 10'h002
    && prefetch_cycles == 5'h01) // see [RULE_09]
    else $error("register operation timing wrong");

  double_ind_a: assert property (accept && op == OP_MOVE_DBL_IND &&
    !cache_hit && wait_states == '0 && ea_clocks == '0 |=>
    total_clocks == 10'h017 && read_cycles == 5'h01
    && prefetch_cycles == 5'h03 && write_cycles == 5'h01)
    // see [RULE_10]
    else $error("double indirect move timing wrong");

  ea_added_a: assert property (accept && op == OP_EA_TO_STAT &&
    cache_hit && wait_states == '0 |=>
    total_clocks == 10'h008 + $past(ea_clocks)) // see [RULE_11]
    else $error("address time not added");

  max_flag_a: assert property (accept |=> max_time ==
    ($past(op) inside {OP_MUL_W, OP_MUL_L, OP_DIVS_W, OP_DIVS_L,
    OP_DIVU_W, OP_DIVU_L})) // see [RULE_12]
    else $error("maximum time flag wrong");

  run_length_a: assert property (done |-> elapsed + 1 == total_clocks
    ##1 !busy) // see [RULE_13]
    else $error("run length differs from total");

  tail_phase_a: assert property (busy && tail_clocks != '0 &&
    elapsed == total_clocks - tail_clocks &&
    elapsed >= head_clocks |-> phase == PH_TAIL) // see [RULE_13]
    else $error("tail phase missed");

endmodule

// file: testbench/ext_memory_model.sv
// external memory model that sets the wait states of every bus cycle
`timescale 1ns/100ps
`include "instruction_cycle_timing_defines.svh"
module ext_memory_model (
  input  wire logic               slow,
  input  wire logic [`WAIT_W-1:0] extra,
  output logic      [`WAIT_W-1:0] wait_states
);
  // prompt memory ends each access in two clocks; slow memory adds waits
  assign wait_states = slow ? extra : '0;
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the instruction cycle model
`timescale 1ns/100ps
`include "instruction_cycle_timing_defines.svh"
module tb_top;
  import cycle_timing_pkg::*;
  logic               clock;
  logic               rstn;
  logic               start;
  op_t                op;
  logic               cache_hit;
  logic               mem_slow;
  logic [`WAIT_W-1:0] mem_waits;
  logic [`WAIT_W-1:0] wait_states;
  logic [`LIST_W-1:0] list_count;
  logic [`EA_W-1:0]   ea_clocks;
  logic               ready;
  logic               busy;
  logic               done;
  phase_t             phase;
  logic [9:0]         elapsed;
  logic [9:0]         head_clocks;
  logic [9:0]         tail_clocks;
  logic [9:0]         total_clocks;
  logic [4:0]         read_cycles;
  logic [4:0]         prefetch_cycles;
  logic [4:0]         write_cycles;
  logic               max_time;
  int                 fail_count;
  int                 samples_checked;

  ext_memory_model mem (
    .slow        (mem_slow),
    .extra       (mem_waits),
    .wait_states (wait_states)
  );

  instruction_cycle_timing DUT (
    .clock(clock), .rstn(rstn), .start(start), .op(op),
    .cache_hit(cache_hit), .wait_states(wait_states),
    .list_count(list_count), .ea_clocks(ea_clocks), .ready(ready),
    .busy(busy), .done(done), .phase(phase), .elapsed(elapsed),
    .head_clocks(head_clocks), .tail_clocks(tail_clocks),
    .total_clocks(total_clocks), .read_cycles(read_cycles),
    .prefetch_cycles(prefetch_cycles), .write_cycles(write_cycles),
    .max_time(max_time)
  );

  always #25 clock = ~clock;

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one operation from request to idle, every busy cycle judged
  task automatic run_op(input op_t o, input logic h, input int w, n, e,
                        tot, hd, tl, r, p, wr, input logic mx);
    phase_t ph;
    @(negedge clock);
    op = o;
    cache_hit = h;
    mem_slow = (w != 0);
    mem_waits = 4'(w);
    list_count = 5'(n);
    ea_clocks = 8'(e);
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    check("total", total_clocks, tot);
    check("head", head_clocks, hd);
    check("tail", tail_clocks, tl);
    check("reads", read_cycles, r);
    check("prefetch", prefetch_cycles, p);
    check("writes", write_cycles, wr);
    check("max_time", max_time, mx);
    for (int k = 1; k <= tot; k++) begin
      ph = (k <= hd) ? PH_HEAD : (k > tot - tl) ? PH_TAIL : PH_BODY;
      check("busy", busy, 1);
      check("done", done, k == tot);
      check("elapsed", elapsed, k - 1);
      check("phase", phase, ph);
      @(negedge clock);
    end
    check("busy_end", busy, 0);
    check("ready_end", ready, 1);
  endtask

  task automatic t_reset;
    check("rst_busy", busy, 0);
    check("rst_ready", ready, 1);
    check("rst_phase", phase, PH_IDLE);
    check("rst_total", total_clocks, 0);
  endtask

  task automatic t_ctl_space;
    run_op(OP_REG_TO_CTL_B, 1, 0, 0, 0, 12, 4, 0, 0, 0, 0, 0);
    run_op(OP_REG_TO_CTL_B, 0, 0, 0, 0, 12, 4, 0, 0, 1, 0, 0);
    run_op(OP_REG_TO_CTL_B, 0, 3, 0, 0, 15, 4, 0, 0, 1, 0, 0);
  endtask

  task automatic t_ctl_stack;
    run_op(OP_REG_TO_CTL_A, 1, 0, 0, 0, 6, 6, 0, 0, 0, 0, 0);
  endtask

  task automatic t_status;
    run_op(OP_EA_TO_STAT, 1, 0, 0, 0, 8, 0, 0, 0, 0, 0, 0);
    run_op(OP_EA_TO_STAT, 0, 0, 0, 3, 13, 0, 0, 0, 2, 0, 0);
  endtask

  task automatic t_alt;
    run_op(OP_ALT_LOAD, 1, 0, 0, 0, 7, 3, 0, 1, 0, 0, 0);
    run_op(OP_ALT_LOAD, 0, 0, 0, 4, 11, 3, 0, 1, 1, 0, 0);
  endtask

  task automatic t_alu;
    run_op(OP_ALU_REG, 1, 0, 0, 0, 2, 2, 0, 0, 0, 0, 0);
    run_op(OP_ALU_REG, 0, 0, 0, 0, 2, 2, 0, 0, 1, 0, 0);
    run_op(OP_ALU_MEM, 1, 0, 0, 0, 3, 0, 1, 0, 0, 1, 0);
    run_op(OP_ALU_MEM, 0, 0, 0, 0, 4, 0, 1, 0, 1, 1, 0);
    run_op(OP_ALU_MEM, 0, 2, 0, 0, 8, 0, 1, 0, 1, 1, 0);
  endtask

  task automatic t_dbl;
    run_op(OP_MOVE_DBL_IND, 1, 0, 0, 0, 20, 4, 0, 1, 0, 1, 0);
    run_op(OP_MOVE_DBL_IND, 0, 0, 0, 0, 23, 4, 0, 1, 3, 1, 0);
  endtask

  task automatic t_list_load;
    run_op(OP_LIST_LOAD, 1, 0, 3, 0, 20, 2, 0, 3, 0, 0, 0);
    run_op(OP_LIST_LOAD, 0, 4, 3, 0, 26, 2, 0, 3, 1, 0, 0);
    run_op(OP_LIST_LOAD, 1, 2, 1, 2, 14, 2, 0, 1, 0, 0, 0);
  endtask

  task automatic t_list_store;
    run_op(OP_LIST_STORE, 1, 1, 3, 0, 12, 2, 2, 0, 0, 3, 0);
    run_op(OP_LIST_STORE, 0, 4, 3, 0, 20, 2, 18, 0, 1, 3, 0);
    run_op(OP_LIST_STORE, 1, 0, 0, 0, 6, 2, 0, 0, 0, 1, 0);
  endtask

  task automatic t_muldiv;
    run_op(OP_DIVS_L, 1, 0, 0, 0, 90, 2, 0, 0, 0, 0, 1);
    run_op(OP_DIVU_W, 0, 0, 0, 0, 44, 2, 0, 0, 1, 0, 1);
    run_op(OP_MUL_W, 1, 0, 0, 0, 28, 2, 0, 0, 0, 0, 1);
  endtask

  // a second request while busy must leave the running one untouched
  task automatic t_refuse;
    @(negedge clock);
    op = OP_REG_TO_CTL_A;
    cache_hit = 1'b1;
    mem_slow = 1'b0;
    start = 1'b1;
    @(negedge clock);
    op = OP_ALU_REG;
    repeat (3) @(negedge clock);
    check("refused_total", total_clocks, 6);
    check("refused_ready", ready, 0);
    start = 1'b0;
    repeat (3) @(negedge clock);
    check("refused_end", busy, 0);
  endtask

  task automatic t_midreset;
    @(negedge clock);
    op = OP_DIVS_L;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    repeat (4) @(negedge clock);
    rstn = 1'b0;
    #1;
    t_reset();
    @(negedge clock);
    rstn = 1'b1;
    run_op(OP_ALU_REG, 1, 0, 0, 0, 2, 2, 0, 0, 0, 0, 0);
  endtask

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    start = 1'b0;
    op = OP_EXCHANGE;
    cache_hit = 1'b1;
    mem_slow = 1'b0;
    mem_waits = '0;
    list_count = '0;
    ea_clocks = '0;
    fail_count = 0;
    samples_checked = 0;
    repeat (4) @(negedge clock);
    t_reset();
    rstn = 1'b1;
    t_ctl_space();
    t_ctl_stack();
    t_status();
    t_alt();
    t_alu();
    t_dbl();
    t_list_load();
    t_list_store();
    t_muldiv();
    t_refuse();
    t_midreset();
    wrap_up();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    wrap_up();
  end
endmodule
